// *** rtl/cc_mode_pkg.sv ***
package cc_mode_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0]  MODE_OFS          = 4'h0;
  localparam logic [3:0]  VALUE_OFS         = 4'h4;
  localparam logic [3:0]  STATUS_OFS        = 4'h8;
  localparam logic [3:0]  COUNT_OFS         = 4'hC;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int          FLAG_IRQ_EN_BIT   = 0;
  localparam int          PWM_EN_BIT        = 1;
  localparam int          TOGGLE_EN_BIT     = 2;
  localparam int          MATCH_EN_BIT      = 3;
  localparam int          FALL_CAP_EN_BIT   = 4;
  localparam int          RISE_CAP_EN_BIT   = 5;
  localparam int          COMP_EN_BIT       = 6;
  localparam int          PWM_WIDTH_SEL_BIT = 7;

  // status register fields
  localparam int          FLAG_BIT          = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_RST          = 8'h00;
  localparam logic [15:0] VALUE_RST         = 16'h0000;
  localparam logic [31:0] RDATA_RST         = 32'h0000_0000;

  // output waveform kinds, one-hot
  typedef enum logic [4:0] {
    WAVE_OFF    = 5'b00001,
    WAVE_TOGGLE = 5'b00010,
    WAVE_PWM8   = 5'b00100,
    WAVE_PWM16  = 5'b01000,
    WAVE_FREQ   = 5'b10000
  } wave_e;

endpackage : cc_mode_pkg

// *** rtl/pin_edge_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for the module pin, then an edge detector
// that only ever looks at the second stage
module pin_edge_sync (
  input  wire logic ref_clk,   // system clock
  input  wire logic sys_rst,   // synchronous reset, active high
  input  wire logic pin_in,    // raw pin level
  output logic      rise,      // one-cycle rising-edge pulse
  output logic      fall       // one-cycle falling-edge pulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // edges are seen one to two cycles after the pin moves
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;

endmodule : pin_edge_sync

`default_nettype wire

// *** rtl/cc_mode_unit.sv ***
`timescale 1ns/100ps
`default_nettype none

module cc_mode_unit #(
  parameter int CNT_W = 16                       // array counter width
) (
  input  wire logic             ref_clk,         // system clock, 125 MHz
  input  wire logic             sys_rst,         // synchronous reset, active high
  input  wire logic [3:0]       wb_adr_i,        // byte address
  input  wire logic [31:0]      wb_dat_i,        // write data
  input  wire logic [3:0]       wb_sel_i,        // byte enables
  input  wire logic             wb_we_i,         // write strobe
  input  wire logic             wb_cyc_i,        // bus cycle
  input  wire logic             wb_stb_i,        // strobe
  output logic [31:0]           wb_dat_o,        // read data
  output logic                  wb_ack_o,        // acknowledge
  input  wire logic [CNT_W-1:0] array_count,     // shared array counter
  input  wire logic             module_pin_i,    // pin level in
  output logic                  module_pin_o,    // pin level out
  output logic                  module_pin_oe,   // pin driven when high
  output logic                  irq_req          // masked flag request
);
  import cc_mode_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       mode_ff,   nxt_mode;
  logic [CNT_W-1:0] value_ff,  nxt_value;
  logic             flag_ff,   nxt_flag;
  logic             pin_ff,    nxt_pin;
  logic             oe_ff,     nxt_oe;
  logic             irq_ff,    nxt_irq;
  logic             ack_ff,    nxt_ack;
  logic [31:0]      rdata_ff,  nxt_rdata;
  wave_e            wave_ff,   nxt_wave;

  logic             rise;
  logic             fall;
  logic             access;
  logic             wr;
  logic             comp_en;
  logic             cap_evt;
  logic             match16;
  logic             match8;
  logic             match;

  // decode shared by read and write paths
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr[3:2] == ofs[3:2]);
  endfunction : hit

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  pin_edge_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (module_pin_i),
    .rise    (rise),
    .fall    (fall)
  );

  // ----------------------------------------------------------------
  // bus qualifiers and compare terms
  // ----------------------------------------------------------------
  // ack answers one cycle after the strobe and drops the cycle after
  assign access  = wb_cyc_i & wb_stb_i & ~ack_ff;
  // a write lands at the edge where the master samples ack, not one edge early,
  // so a request withdrawn before ack never changes a register
  assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign comp_en = mode_ff[COMP_EN_BIT];
  assign cap_evt = (rise & mode_ff[RISE_CAP_EN_BIT]) | (fall & mode_ff[FALL_CAP_EN_BIT]);
  assign match16 = (array_count == value_ff);
  assign match8  = (array_count[7:0] == value_ff[7:0]);
  assign match   = comp_en & match16;

  // ----------------------------------------------------------------
  // waveform selection
  // ----------------------------------------------------------------
  always_comb begin
    nxt_wave = WAVE_OFF;
    if (comp_en) begin
      // toggle plus pwm means frequency output
      if (mode_ff[TOGGLE_EN_BIT] && mode_ff[PWM_EN_BIT]) begin
        nxt_wave = WAVE_FREQ;
      end else if (mode_ff[PWM_EN_BIT]) begin
        // width select only counts with pwm on
        nxt_wave = mode_ff[PWM_WIDTH_SEL_BIT] ? WAVE_PWM16 : WAVE_PWM8;
      end else if (mode_ff[TOGGLE_EN_BIT]) begin
        nxt_wave = WAVE_TOGGLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers, value, flag and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_value = value_ff;
    nxt_flag  = flag_ff;
    nxt_pin   = pin_ff;
    nxt_oe    = (wave_ff != WAVE_OFF);
    nxt_ack   = access;
    nxt_rdata = RDATA_RST;

    // software writes first, so hardware events below win
    if (wr && hit(wb_adr_i, MODE_OFS) && wb_sel_i[0]) begin
      nxt_mode = wb_dat_i[7:0];
    end
    if (wr && hit(wb_adr_i, VALUE_OFS)) begin
      if (wb_sel_i[0]) begin
        nxt_value[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_value[CNT_W-1:8] = wb_dat_i[CNT_W-1:8];
      end
    end
    // flag clears by writing one, an event in the same cycle keeps it set
    if (wr && hit(wb_adr_i, STATUS_OFS) && wb_sel_i[0] && wb_dat_i[FLAG_BIT]) begin
      nxt_flag = 1'b0;
    end

    if (match && mode_ff[MATCH_EN_BIT]) begin
      nxt_flag = 1'b1;
    end
    // capture copies the counter and sets the flag
    if (cap_evt) begin
      nxt_value = array_count;
      nxt_flag  = 1'b1;
    end

    // pin waveform, frequency mode advances the low byte by the high byte
    case (wave_ff)
      WAVE_TOGGLE: begin
        if (match) begin
          nxt_pin = ~pin_ff;
        end
      end
      WAVE_PWM8: begin
        // low while below the 8-bit threshold
        nxt_pin = (array_count[7:0] >= value_ff[7:0]);
      end
      WAVE_PWM16: begin
        nxt_pin = (array_count >= value_ff);
      end
      WAVE_FREQ: begin
        // half period set by the high byte
        if (match8) begin
          nxt_pin        = ~pin_ff;
          nxt_value[7:0] = 8'(value_ff[7:0] + value_ff[15:8]);
        end
      end
      default: begin
        nxt_pin = pin_ff;
      end
    endcase

    // read mux, address bits 3:2 map all four words; bits outside each field read zero
    if (access && !wb_we_i) begin
      if (hit(wb_adr_i, MODE_OFS)) begin
        nxt_rdata[7:0] = mode_ff;
      end else if (hit(wb_adr_i, VALUE_OFS)) begin
        nxt_rdata[CNT_W-1:0] = value_ff;
      end else if (hit(wb_adr_i, STATUS_OFS)) begin
        nxt_rdata[FLAG_BIT] = flag_ff;
      end else if (hit(wb_adr_i, COUNT_OFS)) begin
        nxt_rdata[CNT_W-1:0] = array_count;
      end
    end

    nxt_irq = flag_ff & mode_ff[FLAG_IRQ_EN_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_ff  <= MODE_RST;
      value_ff <= VALUE_RST;
      flag_ff  <= 1'b0;
      pin_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      irq_ff   <= 1'b0;
      ack_ff   <= 1'b0;
      rdata_ff <= RDATA_RST;
      wave_ff  <= WAVE_OFF;
    end else begin
      mode_ff  <= nxt_mode;
      value_ff <= nxt_value;
      flag_ff  <= nxt_flag;
      pin_ff   <= nxt_pin;
      oe_ff    <= nxt_oe;
      irq_ff   <= nxt_irq;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      wave_ff  <= nxt_wave;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign wb_dat_o      = rdata_ff;
  assign wb_ack_o      = ack_ff;
  assign module_pin_o  = pin_ff;
  assign module_pin_oe = oe_ff;
  assign irq_req       = irq_ff;

endmodule : cc_mode_unit

`default_nettype wire

// *** testbench/cc_mode_unit_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module cc_mode_unit_assertions #(
  parameter int CNT_W = 16                  // counter width
) (
  input wire logic             ref_clk,       // clock
  input wire logic             sys_rst,       // reset
  input wire logic [3:0]       wb_adr_i,      // address
  input wire logic [31:0]      wb_dat_i,      // wdata
  input wire logic [3:0]       wb_sel_i,      // lanes
  input wire logic             wb_we_i,       // write
  input wire logic             wb_cyc_i,      // cycle
  input wire logic             wb_stb_i,      // strobe
  input wire logic [31:0]      wb_dat_o,      // rdata
  input wire logic             wb_ack_o,      // ack
  input wire logic [CNT_W-1:0] array_count,   // counter
  input wire logic             module_pin_i,  // pin in
  input wire logic             module_pin_o,  // pin out
  input wire logic             module_pin_oe, // pin drive
  input wire logic             irq_req        // request
);
  import cc_mode_pkg::*;
  logic [7:0]  mode_ff, nxt_mode;
  logic [15:0] val_ff, nxt_val;
  logic        wr_ok, pwm_on;
  assign wr_ok  = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign pwm_on = mode_ff[COMP_EN_BIT] && mode_ff[PWM_EN_BIT] && !mode_ff[TOGGLE_EN_BIT];
  // ----------------------------------------
  // shadows of bus writes
  // ----------------------------------------
  // value shadow is blind to capture, so it only holds while capture is off
  always_comb begin
    nxt_mode = mode_ff;
    nxt_val  = val_ff;
    if (wr_ok && wb_adr_i == MODE_OFS && wb_sel_i[0]) nxt_mode = wb_dat_i[7:0];
    if (wr_ok && wb_adr_i == VALUE_OFS) nxt_val = wb_dat_i[15:0];
  end
  always_ff @(posedge ref_clk) begin
    mode_ff <= sys_rst ? MODE_RST : nxt_mode;
    val_ff  <= sys_rst ? VALUE_RST : nxt_val;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == RDATA_RST; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_rst_out; $fell(sys_rst) |-> !irq_req && !module_pin_oe && !module_pin_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
  property p_mode_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == MODE_OFS |-> wb_dat_o == {24'h00_0000, mode_ff};
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
  property p_irq_mask; irq_req |-> $past(mode_ff[FLAG_IRQ_EN_BIT]); endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_oe_comp; !mode_ff[COMP_EN_BIT] [*3] |-> !module_pin_oe; endproperty
  a_oe_comp: assert property (p_oe_comp) else $error("pin driven, comparator off");
  property p_oe_wave; !(mode_ff[TOGGLE_EN_BIT] || mode_ff[PWM_EN_BIT]) [*3] |-> !module_pin_oe;
  endproperty
  a_oe_wave: assert property (p_oe_wave) else $error("pin driven, no wave");
  property p_pwm;
    (pwm_on && $stable(mode_ff) && $stable(val_ff)) [*3] |-> module_pin_o == ($past(mode_ff[7])
      ? $past(array_count) >= $past(val_ff) : $past(array_count[7:0]) >= $past(val_ff[7:0]));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level");
  c_wr: cover property (wr_ok);
  c_irq: cover property (irq_req);
  c_pin: cover property (module_pin_oe && module_pin_o);
endmodule : cc_mode_unit_assertions
`default_nettype wire

// *** testbench/pin_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic drive_en,  // far side drives
  input  wire logic drive_lvl, // far-side level
  input  wire logic pin_o,     // device level
  input  wire logic pin_oe,    // device drives
  output logic      pin_i      // wire level
);
  // an undriven pin sits at its pull-up; contention is not modelled
  assign pin_i = pin_oe ? pin_o : (drive_en ? drive_lvl : 1'b1);
endmodule : pin_partner
`default_nettype wire

// *** testbench/cc_mode_unit_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module cc_mode_unit_tb;
  import cc_mode_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd_dat;
  logic        drive_lvl = 1'b0, pin_i, pin_o, pin_oe, irq_req, wb_ack_o, p0;
  logic [15:0] array_count = 16'h0000, exp_val;
  logic [7:0]  mt [4] = '{8'h49, 8'h48, 8'h40, 8'h08};
  int          error_cnt = 0, samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  cc_mode_unit dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .array_count(array_count),
    .module_pin_i(pin_i), .module_pin_o(pin_o), .module_pin_oe(pin_oe), .irq_req(irq_req));
  pin_partner pin_u (.drive_en(1'b1), .drive_lvl(drive_lvl), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  // request held until ack is sampled, released at that edge
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      chk("bus ack", 32'h1, 32'h0);
      final_report;
    end
    rd_dat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb_xfer
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    wb_xfer(1'b0, MODE_OFS, 32'h0000_0000);
    chk("mode reset", 32'h0000_0000, rd_dat);
    for (int i = 0; i < 2; i++) begin
      wb_xfer(1'b1, MODE_OFS, i ? 32'h0000_005A : 32'h0000_00A5);
      wb_xfer(1'b0, MODE_OFS, 32'h0000_0000);
      chk("mode readback", i ? 32'h0000_005A : 32'h0000_00A5, rd_dat);
    end
    wb_xfer(1'b1, MODE_OFS, 32'h0000_0000);
    tick(8);
    exp_val = 16'h0000;
    // rise-only mode then fall-only mode, each seeing a rise and a fall
    for (int i = 0; i < 4; i++) begin
      wb_xfer(1'b1, MODE_OFS, i < 2 ? 32'h0000_0020 : 32'h0000_0010);
      wb_xfer(1'b1, STATUS_OFS, 32'h0000_0001);
      array_count <= {14'h0400, i[1:0]};
      drive_lvl <= ~drive_lvl;
      if (i == 0 || i == 3) exp_val = {14'h0400, i[1:0]};
      tick(8);
      wb_xfer(1'b0, VALUE_OFS, 32'h0000_0000);
      chk("capture value", {16'h0000, exp_val}, rd_dat);
      wb_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("capture flag", {31'h0, i == 0 || i == 3}, {31'h0, rd_dat[0]});
    end
    wb_xfer(1'b1, VALUE_OFS, 32'h0000_0077);
    for (int i = 0; i < 4; i++) begin
      array_count <= 16'h0000;
      wb_xfer(1'b1, MODE_OFS, {24'h00_0000, mt[i]});
      wb_xfer(1'b1, STATUS_OFS, 32'h0000_0001);
      array_count <= 16'h0077;
      tick(4);
      wb_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("match flag", {31'h0, i < 2}, {31'h0, rd_dat[0]});
      chk("irq", {31'h0, i == 0}, {31'h0, irq_req});
    end
    array_count <= 16'h0000;
    wb_xfer(1'b1, MODE_OFS, 32'h0000_0044);
    tick(4);
    p0 = pin_o;
    chk("toggle drive", 32'h1, {31'h0, pin_oe});
    array_count <= 16'h0077;
    tick(1);
    array_count <= 16'h0000;
    tick(4);
    chk("toggle pin", {31'h0, ~p0}, {31'h0, pin_o});
    // counts chosen so 8-bit and 16-bit compares disagree
    wb_xfer(1'b1, VALUE_OFS, 32'h0000_0180);
    for (int i = 0; i < 4; i++) begin
      wb_xfer(1'b1, MODE_OFS, i < 2 ? 32'h0000_0042 : 32'h0000_00C2);
      array_count <= i[0] ? 16'h0200 : 16'h0090;
      tick(4);
      chk("pwm pin", {31'h0, ~(i[0] ^ i[1])}, {31'h0, pin_o});
    end
    wb_xfer(1'b1, MODE_OFS, 32'h0000_0080);
    tick(4);
    chk("width only", 32'h0, {31'h0, pin_oe});
    array_count <= 16'h0000;
    wb_xfer(1'b1, VALUE_OFS, 32'h0000_1010);
    wb_xfer(1'b1, MODE_OFS, 32'h0000_0046);
    tick(4);
    p0 = pin_o;
    for (int k = 0; k < 64; k++) begin
      array_count <= k[15:0];
      tick(1);
    end
    tick(4);
    chk("freq pin", {31'h0, ~p0}, {31'h0, pin_o});
    wb_xfer(1'b0, VALUE_OFS, 32'h0000_0000);
    chk("freq step", 32'h0000_1040, rd_dat);
    wb_xfer(1'b0, COUNT_OFS, 32'h0000_0000);
    chk("count read", 32'h0000_003F, rd_dat);
    final_report;
  end
endmodule : cc_mode_unit_tb
bind cc_mode_unit cc_mode_unit_assertions #(.CNT_W(CNT_W)) chk_u (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .array_count(array_count), .module_pin_i(module_pin_i),
  .module_pin_o(module_pin_o), .module_pin_oe(module_pin_oe), .irq_req(irq_req));
`default_nettype wire
